//--- rtl/timer_output_compare.sv
/*
  Timer output-compare top: AHB-Lite register slave, slave-mode trigger
  handling, break logic, interrupt flags and the output pin stage.
  Assumes a single AHB-Lite master, word accesses only, and that the
  trigger, clear and break pins are asynchronous to hclk.
*/
`timescale 1ns/10ps
`include "timer_oc_map.svh"
module timer_output_compare
  import timer_oc_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int REP_W = 8
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic trigger_in,
  input wire logic ref_clear_in,
  input wire logic break_input,
  input wire logic second_break_input,
  output logic oc_out,
  output logic oc_oe,
  output logic irq
);
  logic [`CTRL_BITS-1:0] ctrl_q;
  logic [CNT_W-1:0] period_value;
  logic [CNT_W-1:0] compare_value;
  logic [REP_W-1:0] repetition_count;
  logic [`ST_BITS-1:0] status_q;
  logic [`ST_BITS-1:0] mask_q;
  logic [`ST_BITS-1:0] status_set;
  logic moe_q;
  logic started_q;
  logic wr_q;
  logic [7:0] addr_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic accept;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic trig_prev_q;
  logic trig_s;
  logic clr_s;
  logic brk_s;
  logic trig_rise;
  logic cnt_reset;
  logic run;
  logic update;
  logic cc_event;
  logic oc_ref;
  logic dir_down;
  logic [CNT_W-1:0] counter_value;
  logic oc_out_q;
  slave_mode_t sms;
  oc_mode_t mode;
  logic ctrl_wr;

  assign accept = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // Address phase capture; only word transfers are expected, hsize unused
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else
    begin
      wr_q <= accept && hwrite;
      addr_q <= haddr[7:0];
    end
  end

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (haddr[7:0])
      `OFS_CTRL:
      begin
        rdata_d[`CTRL_BITS-1:0] = ctrl_q;
        rdata_d[`CTRL_MOE] = moe_q;
      end
      `OFS_PERIOD: rdata_d[CNT_W-1:0] = period_value;
      `OFS_COMPARE: rdata_d[CNT_W-1:0] = compare_value;
      `OFS_REPEAT: rdata_d[REP_W-1:0] = repetition_count;
      `OFS_COUNT: rdata_d[CNT_W-1:0] = counter_value;
      `OFS_STATUS: rdata_d[`ST_BITS-1:0] = status_q;
      `OFS_MASK: rdata_d[`ST_BITS-1:0] = mask_q;
      `OFS_OUTSTAT: rdata_d[3:0] = {dir_down, moe_q, oc_out_q, oc_ref};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data are sampled in the address phase and stand in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rdata_q <= 32'h0000_0000;
    else if (accept && !hwrite)
      rdata_q <= rdata_d;
  end

  assign ctrl_wr = wr_q && (addr_q == `OFS_CTRL);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_q <= `RST_CTRL;
    else if (ctrl_wr)
      ctrl_q <= hwdata[`CTRL_BITS-1:0];
  end

  // New compare and period take effect on the following cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      period_value <= `RST_PERIOD;
      compare_value <= `RST_COMPARE;
      repetition_count <= `RST_REPEAT;
    end
    else if (wr_q)
    begin
      if (addr_q == `OFS_PERIOD)
        period_value <= hwdata[CNT_W-1:0];
      if (addr_q == `OFS_COMPARE)
        compare_value <= hwdata[CNT_W-1:0];
      if (addr_q == `OFS_REPEAT)
        repetition_count <= hwdata[REP_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mask_q <= '0;
    else if (wr_q && addr_q == `OFS_MASK)
      mask_q <= hwdata[`ST_BITS-1:0];
  end

  // Pins are asynchronous: two flops before any use
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end
    else
    begin
      sync1_q <= {second_break_input, break_input, ref_clear_in, trigger_in};
      sync2_q <= sync1_q;
    end
  end

  assign trig_s = sync2_q[0];
  assign clr_s = sync2_q[1];
  assign brk_s = sync2_q[2] | sync2_q[3];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      trig_prev_q <= 1'b0;
    else
      trig_prev_q <= trig_s;
  end

  assign sms = slave_mode_t'(ctrl_q[`CTRL_SMS_HI:`CTRL_SMS_LO]);
  assign mode = oc_mode_t'(ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO]);
  assign trig_rise = trig_s && !trig_prev_q;
  assign cnt_reset = trig_rise && (sms != SLV_OFF);

  // Reset plus trigger: counting starts at the first trigger edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      started_q <= 1'b0;
    else if (!ctrl_q[`CTRL_EN])
      started_q <= 1'b0;
    else if (trig_rise)
      started_q <= 1'b1;
  end

  always_comb
  begin
    case (sms)
      SLV_OFF: run = ctrl_q[`CTRL_EN];
      SLV_RESET: run = ctrl_q[`CTRL_EN];
      SLV_RESET_TRIG: run = ctrl_q[`CTRL_EN] && started_q;
      SLV_GATED_RESET: run = ctrl_q[`CTRL_EN] && trig_s;
      default: run = 1'b0;
    endcase
  end

  oc_counter #(
    .CNT_W(CNT_W),
    .REP_W(REP_W)
  ) u_counter (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run),
    .center(ctrl_q[`CTRL_CENTER]),
    .period(period_value),
    .repeat_load(repetition_count),
    .reset_req(cnt_reset),
    .counter_value(counter_value),
    .dir_down(dir_down),
    .update(update)
  );

  oc_channel #(
    .CNT_W(CNT_W)
  ) u_channel (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run),
    .counter_value(counter_value),
    .compare_value(compare_value),
    .mode(mode),
    .clear_en(ctrl_q[`CTRL_CLREN]),
    .clear_in(clr_s),
    .counter_reset(cnt_reset),
    .update(update),
    .compare_event(cc_event),
    .oc_ref(oc_ref)
  );

  // Break dominates software; auto re-enable waits for an update event
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      moe_q <= 1'b0;
    else if (brk_s)
      moe_q <= 1'b0;
    else if (ctrl_wr)
      moe_q <= hwdata[`CTRL_MOE];
    else if (ctrl_q[`CTRL_AUTO_REEN] && update)
      moe_q <= 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      oc_out_q <= 1'b0;
      oc_oe <= 1'b0;
    end
    else
    begin
      oc_out_q <= moe_q && (oc_ref ^ ctrl_q[`CTRL_POL]);
      oc_oe <= moe_q;
    end
  end

  assign oc_out = oc_out_q;

  assign status_set[`ST_CC] = cc_event;
  assign status_set[`ST_UPD] = update;
  assign status_set[`ST_BRK] = brk_s;

  // Write one to clear; a same-cycle event wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status_q <= '0;
    else if (wr_q && addr_q == `OFS_STATUS)
      status_q <= (status_q & ~hwdata[`ST_BITS-1:0]) | status_set;
    else
      status_q <= status_q | status_set;
  end

  assign irq = |(status_q & mask_q);
endmodule

//--- rtl/timer_oc_map.svh
/*
  Register offsets, field positions and reset values of the timer
  output-compare block. Assumes a 32-bit bus with word-aligned registers.
*/
// Function
// - Event on every counted cycle counter equals compare
// - Back-to-back matches both give events, period-then-zero too
// - Center crest: period-1 then period, two events
// - Center valley: 1 then 0, two events
// - Toggle mode inverts output on every event
// - Center events set flag and raise interrupt
// - Reference clear works in every slave mode
// - Counter reset after clear restores PWM next period
// - Break inputs clear outputs; optional auto re-enable
`ifndef TIMER_OC_MAP_SVH
`define TIMER_OC_MAP_SVH

`define OFS_CTRL 8'h00
`define OFS_PERIOD 8'h04
`define OFS_COMPARE 8'h08
`define OFS_REPEAT 8'h0c
`define OFS_COUNT 8'h10
`define OFS_STATUS 8'h14
`define OFS_MASK 8'h18
`define OFS_OUTSTAT 8'h1c

`define CTRL_EN 0
`define CTRL_CENTER 1
`define CTRL_MODE_LO 2
`define CTRL_MODE_HI 4
`define CTRL_AUTO_REEN 5
`define CTRL_MOE 6
`define CTRL_SMS_LO 7
`define CTRL_SMS_HI 8
`define CTRL_CLREN 9
`define CTRL_POL 10
`define CTRL_BITS 11

`define ST_CC 0
`define ST_UPD 1
`define ST_BRK 2
`define ST_BITS 3

`define RST_CTRL 11'h000
`define RST_PERIOD 16'hffff
`define RST_COMPARE 16'h0000
`define RST_REPEAT 8'h00

`endif

//--- rtl/timer_oc_pkg.sv
/*
  Types shared by the timer output-compare design.
  Assumes nothing of its surroundings.
*/
package timer_oc_pkg;
  typedef enum logic [2:0] {
    OC_FROZEN,
    OC_ACT_ON_MATCH,
    OC_INACT_ON_MATCH,
    OC_TOGGLE,
    OC_FORCE_LO,
    OC_FORCE_HI,
    OC_PWM1,
    OC_PWM2
  } oc_mode_t;

  typedef enum logic [1:0] {
    SLV_OFF,
    SLV_RESET,
    SLV_RESET_TRIG,
    SLV_GATED_RESET
  } slave_mode_t;

  typedef enum logic {
    DIR_UP,
    DIR_DOWN
  } dir_t;
endpackage

//--- rtl/oc_counter.sv
/*
  Timer counter: edge-aligned up counting or center-aligned up/down,
  with a repetition down-counter that gates the update event.
  Assumes run and reset_req come from logic on the same clock.
*/
`timescale 1ns/10ps
module oc_counter
  import timer_oc_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int REP_W = 8
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic center,
  input wire logic [CNT_W-1:0] period,
  input wire logic [REP_W-1:0] repeat_load,
  input wire logic reset_req,
  output logic [CNT_W-1:0] counter_value,
  output logic dir_down,
  output logic update
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [REP_W-1:0] rep_q;
  dir_t dir_q;
  dir_t dir_d;
  logic wrap;

  always_comb
  begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    wrap = 1'b0;
    if (!center)
    begin
      dir_d = DIR_UP;
      if (cnt_q >= period)
      begin
        cnt_d = '0;
        wrap = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q + 1'b1;
      end
    end
    else
    begin
      case (dir_q)
        DIR_UP:
        begin
          // Crest compares against the live period, which may be new
          if (cnt_q >= period)
          begin
            dir_d = DIR_DOWN;
            cnt_d = (period == '0) ? '0 : period - 1'b1;
            wrap = 1'b1;
          end
          else
          begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        DIR_DOWN:
        begin
          if (cnt_q == '0)
          begin
            dir_d = DIR_UP;
            cnt_d = (period == '0) ? '0 : {{(CNT_W-1){1'b0}}, 1'b1};
            wrap = 1'b1;
          end
          else
          begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        default:
        begin
          dir_d = DIR_UP;
          cnt_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_q <= '0;
      dir_q <= DIR_UP;
    end
    else if (reset_req)
    begin
      cnt_q <= '0;
      dir_q <= DIR_UP;
    end
    else if (run)
    begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rep_q <= '0;
    else if (reset_req || (run && wrap && rep_q == '0))
      rep_q <= repeat_load;
    else if (run && wrap)
      rep_q <= rep_q - 1'b1;
  end

  assign update = reset_req || (run && wrap && rep_q == '0);
  assign counter_value = cnt_q;
  assign dir_down = (dir_q == DIR_DOWN);
endmodule

//--- rtl/oc_channel.sv
/*
  One compare channel: match detection, output reference modes and the
  reference clear latch.
  Assumes clear_in is already synchronised to hclk.
*/
`timescale 1ns/10ps
module oc_channel
  import timer_oc_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic [CNT_W-1:0] counter_value,
  input wire logic [CNT_W-1:0] compare_value,
  input wire oc_mode_t mode,
  input wire logic clear_en,
  input wire logic clear_in,
  input wire logic counter_reset,
  input wire logic update,
  output logic compare_event,
  output logic oc_ref
);
  logic ref_q;
  logic clr_q;
  logic below;

  // Plain equality each counted cycle, so back-to-back matches never merge
  assign compare_event = run && (counter_value == compare_value);
  assign below = counter_value < compare_value;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ref_q <= 1'b0;
    else
    begin
      case (mode)
        OC_FROZEN: ref_q <= ref_q;
        OC_ACT_ON_MATCH: ref_q <= ref_q | compare_event;
        OC_INACT_ON_MATCH: ref_q <= ref_q & ~compare_event;
        OC_TOGGLE: ref_q <= ref_q ^ compare_event;
        OC_FORCE_LO: ref_q <= 1'b0;
        OC_FORCE_HI: ref_q <= 1'b1;
        OC_PWM1: ref_q <= below;
        OC_PWM2: ref_q <= ~below;
        default: ref_q <= 1'b0;
      endcase
    end
  end

  // Counter reset also releases the latch, so the next period starts active
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      clr_q <= 1'b0;
    else if (clear_en && clear_in)
      clr_q <= 1'b1;
    else if (update || counter_reset)
      clr_q <= 1'b0;
  end

  assign oc_ref = ref_q & ~clr_q;
endmodule

//--- bench/timer_oc_props.sv
/*
  Port-level assertions for the timer output-compare top.
  Assumes one clock domain; bound into every instance of the top.
*/
`timescale 1ns/10ps
module timer_oc_props
#(
  parameter int CNT_W = 16,
  parameter int REP_W = 8
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic trigger_in,
  input wire logic ref_clear_in,
  input wire logic break_input,
  input wire logic second_break_input,
  input wire logic oc_out,
  input wire logic oc_oe,
  input wire logic irq
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic rd_take;
  logic wr_take;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign wr_take = hsel && hready && htrans[1] && hwrite;
  AST_READY_ALWAYS: assert property (hreadyout)
    else $error("wait state seen");
  AST_RESP_OKAY: assert property (!hresp)
    else $error("error response seen");
  AST_RDATA_HOLDS: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved without a read");
  AST_BREAK_CUTS: assert property (break_input [*5] |=> !oc_oe)
    else $error("break left output enabled");
  AST_BREAK2_CUTS: assert property (second_break_input [*5] |=> !oc_oe)
    else $error("second break left output enabled");
  AST_IDLE_LOW: assert property (!oc_oe |-> !oc_out)
    else $error("pin high while disabled");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_take, 2))
    else $error("interrupt dropped without a write");
  AST_RESET_QUIET: assert property ($rose(hresetn) |-> !oc_oe && !irq)
    else $error("outputs active after reset");
  cover property ($rose(irq));
  cover property ($fell(oc_oe));
  cover property ($rose(oc_out) ##1 $fell(oc_out));
endmodule
bind timer_output_compare timer_oc_props #(.CNT_W(CNT_W), .REP_W(REP_W))
  timer_oc_props_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .trigger_in(trigger_in),
  .ref_clear_in(ref_clear_in), .break_input(break_input),
  .second_break_input(second_break_input), .oc_out(oc_out),
  .oc_oe(oc_oe), .irq(irq));

//--- bench/load_model.sv
/*
  Load on the timer output pin: run lengths, one-cycle pulses and time
  spent high.
  Assumes a pull-down on the pin while the driver is released.
*/
`timescale 1ns/10ps
module load_model
(
  input wire logic hclk,
  input wire logic oc_out,
  input wire logic oc_oe,
  output int min_run,
  output int high_cnt,
  output int short_cnt
);
  logic pin;
  logic last_q = 1'b0;
  int run_q = 1000;
  // Pull-down wins once the driver lets go
  assign pin = oc_oe ? oc_out : 1'b0;
  initial min_run = 1000;
  initial high_cnt = 0;
  initial short_cnt = 0;
  always @(posedge hclk)
  begin
    last_q <= pin;
    run_q <= (pin != last_q) ? 1 : run_q + 1;
    if (pin != last_q && run_q < min_run)
      min_run <= run_q;
    if (pin)
      high_cnt <= high_cnt + 1;
    // Counted apart, since min_run never recovers once it hits 1
    if (pin != last_q && run_q == 1)
      short_cnt <= short_cnt + 1;
  end
endmodule

//--- bench/tb_timer_output_compare.sv
/*
  Self-checking bench for the timer output-compare top: register
  traffic, compare toggling, interrupt, break and reference clear.
  Assumes the design, its map header and the load model.
*/
`timescale 1ns/10ps
`include "timer_oc_map.svh"
module tb_timer_output_compare;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic trigger_in = 1'b0, ref_clear_in = 1'b0;
  logic break_input = 1'b0, second_break_input = 1'b0;
  logic hreadyout, hresp, oc_out, oc_oe, irq;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, v;
  logic [31:0] seed = 32'hd9a1_3ba9;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int min_run, high_cnt, short_cnt, h;
  // Writable registers and their implemented widths
  logic [7:0] ofs [4] = '{`OFS_PERIOD, `OFS_COMPARE, `OFS_REPEAT, `OFS_MASK};
  logic [31:0] msk [4] = '{32'hffff, 32'hffff, 32'hff, 32'h7};

  timer_output_compare timer_output_compare_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .trigger_in(trigger_in), .ref_clear_in(ref_clear_in),
    .break_input(break_input), .second_break_input(second_break_input),
    .oc_out(oc_out), .oc_oe(oc_oe), .irq(irq));
  load_model load_model_i (.hclk(hclk), .oc_out(oc_out), .oc_oe(oc_oe),
    .min_run(min_run), .high_cnt(high_cnt), .short_cnt(short_cnt));

  always #5 hclk = ~hclk;

  task automatic wrap_up();
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Generous ceiling; the sequence needs well under a thousand cycles
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      wrap_up();
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One single transfer; data phase held until ready
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(r & m, exp);
  endtask

  // Old compare hits nine counts after the read of at, the new one next
  task automatic pair(input logic [31:0] first, input logic [31:0] second,
    input logic [31:0] at);
    int base;
    bus(1'b1, `OFS_COMPARE, first);
    // Lets any pulse from the first change be counted before the base
    repeat (25) @(posedge hclk);
    base = short_cnt;
    r = 32'hffff_ffff;
    for (int n = 0; n < 40 && r !== at; n++)
      bus(1'b0, `OFS_COUNT, 32'h0);
    repeat (5) @(posedge hclk);
    bus(1'b1, `OFS_COMPARE, second);
    repeat (40) @(posedge hclk);
    chk(32'(short_cnt - base), 32'h1);
  endtask

  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rc(`OFS_CTRL, 32'hffff_ffff, 32'h0);
    rc(`OFS_PERIOD, 32'hffff_ffff, 32'hffff);
    rc(8'h40, 32'hffff_ffff, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      v = xs();
      bus(1'b1, ofs[i], v);
      rc(ofs[i], 32'hffff_ffff, v & msk[i]);
    end
    bus(1'b1, `OFS_COUNT, 32'h5);
    rc(`OFS_COUNT, 32'hffff_ffff, 32'h0);
    bus(1'b1, `OFS_REPEAT, 32'h0);
    bus(1'b1, `OFS_MASK, 32'h1);
    bus(1'b1, `OFS_PERIOD, 32'ha);
    bus(1'b1, `OFS_COMPARE, 32'ha);
    bus(1'b1, `OFS_CTRL, 32'h4d);
    // Read at count 6 puts the next data phase on count 10
    r = 32'h0;
    for (int n = 0; n < 40 && r !== 32'h6; n++)
    begin
      bus(1'b0, `OFS_COUNT, 32'h0);
      chk(32'(r > 32'ha), 32'h0);
    end
    bus(1'b1, `OFS_COMPARE, 32'h0);
    bus(1'b1, `OFS_COMPARE, 32'ha);
    repeat (20) @(posedge hclk);
    chk(32'(min_run), 32'h1);
    rc(`OFS_STATUS, 32'h1, 32'h1);
    bus(1'b1, `OFS_CTRL, 32'h0);
    bus(1'b1, `OFS_STATUS, 32'h7);
    @(posedge hclk);
    chk(32'(irq), 32'h0);
    bus(1'b1, `OFS_CTRL, 32'h4f);
    repeat (30) @(posedge hclk);
    chk(32'(irq), 32'h1);
    bus(1'b1, `OFS_MASK, 32'h0);
    @(posedge hclk);
    chk(32'(irq), 32'h0);
    pair(32'h9, 32'ha, 32'h0);
    pair(32'h1, 32'h0, 32'ha);
    bus(1'b1, `OFS_COMPARE, 32'h5);
    bus(1'b1, `OFS_CTRL, 32'h79);
    break_input <= 1'b1;
    repeat (8) @(posedge hclk);
    rc(`OFS_OUTSTAT, 32'h4, 32'h0);
    rc(`OFS_STATUS, 32'h4, 32'h4);
    break_input <= 1'b0;
    repeat (40) @(posedge hclk);
    chk(32'(oc_oe), 32'h1);
    bus(1'b1, `OFS_CTRL, 32'h59);
    second_break_input <= 1'b1;
    repeat (8) @(posedge hclk);
    second_break_input <= 1'b0;
    repeat (40) @(posedge hclk);
    chk(32'(oc_oe), 32'h0);
    bus(1'b1, `OFS_PERIOD, 32'h28);
    bus(1'b1, `OFS_COMPARE, 32'h14);
    for (int sm = 1; sm < 4; sm++)
    begin
      trigger_in <= 1'b0;
      bus(1'b1, `OFS_CTRL, 32'h259 | 32'(sm << 7));
      repeat (4) @(posedge hclk);
      trigger_in <= 1'b1;
      repeat (4) @(posedge hclk);
      ref_clear_in <= 1'b1;
      repeat (4) @(posedge hclk);
      ref_clear_in <= 1'b0;
      rc(`OFS_OUTSTAT, 32'h1, 32'h0);
      trigger_in <= 1'b0;
      repeat (2) @(posedge hclk);
      trigger_in <= 1'b1;
      h = high_cnt;
      repeat (15) @(posedge hclk);
      chk(32'(high_cnt != h), 32'h1);
    end
    wrap_up();
  end
endmodule
